/* File: hw/avb_pkg.sv */
// Purpose: Shared constants and pin bundle for the byte-wide AV stream port.
// Assumes: 100 MHz system clock on both ends, Wishbone classic register access.
// Notes:   Pin bundle fields carry one bit per pin; enables are per-bit masks.
// Functional notes
// - Port transmits or receives; default transmit.
// - Receiver drives CRC error flag per packet.
// - Receiver drives sequence loss flag per packet.
// - Source pulses packet end on short packets.
// - Pins sampled on application clock rising edge.
// - Device clock selectable 24.576, 12.288, 6.144 MHz; the divider halves of 2, 4, 8 cycles give 25, 12.5, 6.25 MHz.
// - Transmit frame sync input gets timestamped.
// - Receive frame sync output from timestamp field.
// - Six pending timestamp fields are buffered.
// - Tag pin input on transmit, output receive.
// - Driver asserts byte valid with each byte.
// - Data bus eight bits, bit 7 MSB.
// - Packet start marks first byte of packet.
// - Start meets byte valid exactly once.
// - Receiver holds start until first byte out.
// - Receiver withholds bytes while ready inactive.
// - Receiver samples ready through one stage.
// - Source keeps valid low while ready inactive.
// - Sink accepts byte when ready just dropped.
package avb_pkg;

  localparam int SYS_KHZ = 100000;
  localparam int F24_KHZ = 24576;
  localparam int F12_KHZ = 12288;
  localparam int F6_KHZ  = 6144;

  function automatic int avb_half_cyc(input int khz);
    int h;
    h = SYS_KHZ / (2 * khz);
    return (h < 1) ? 1 : h;
  endfunction

  localparam logic [3:0] HALF_24 = 4'(avb_half_cyc(F24_KHZ));
  localparam logic [3:0] HALF_12 = 4'(avb_half_cyc(F12_KHZ));
  localparam logic [3:0] HALF_6  = 4'(avb_half_cyc(F6_KHZ));

  localparam logic [1:0] FSEL_24 = 2'h0;
  localparam logic [1:0] FSEL_12 = 2'h1;

  localparam logic [7:0] OFS_GCS   = 8'h18;
  localparam logic [7:0] OFS_TXPK  = 8'h20;
  localparam logic [7:0] OFS_TXCTL = 8'h34;
  localparam logic [7:0] OFS_RXPK  = 8'h40;
  localparam logic [7:0] OFS_RXCTL = 8'h54;
  localparam logic [7:0] OFS_TXHQ2 = 8'h60;
  localparam logic [7:0] OFS_RXHQ2 = 8'h64;

  localparam int BIT_DIR   = 0;
  localparam int BIT_CLKOE = 0;
  localparam int FSEL_LO   = 1;
  localparam int FSEL_HI   = 2;
  localparam int BIT_TAG   = 0;

  localparam int TS_W     = 16;
  localparam int TS_DEPTH = 6;
  localparam int CODEC_HALF = 8;

  localparam logic [31:0] REG_RST = 32'h0000_0000;

  typedef struct packed {
    logic       clk;
    logic [7:0] data;
    logic       valid;
    logic       start;
    logic       ready;
    logic       fsync;
    logic       tag;
    logic       crc_err;
    logic       seq_loss;
    logic       pkt_end;
  } avb_pins_t;

endpackage

/* File: hw/avb_link_if.sv */
// Purpose: Joins the device end and the codec end of the AV stream port.
// Assumes: Each end drives a pin only where its enable bit is set.
// Notes:   Undriven pins read low; the ends never enable the same pin at once.
`timescale 1ns/1ps
interface avb_link_if;
  import avb_pkg::*;

  avb_pins_t dev_o;
  avb_pins_t dev_oe;
  avb_pins_t cod_o;
  avb_pins_t cod_oe;
  avb_pins_t pins;

  assign pins = (dev_o & dev_oe) | (cod_o & cod_oe);

  modport dev (output dev_o, output dev_oe, input pins);
  modport codec (output cod_o, output cod_oe, input pins);
endinterface

/* File: hw/avb_dev.sv */
// Purpose: Link-side end of the AV stream port with its Wishbone register file.
// Assumes: Link pins arrive asynchronously and pass two flip-flops first.
// Notes:   Pin activity other than the app clock and the tag pin is keyed to detected application clock rising edges.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module avb_dev
  import avb_pkg::*;
#(
  parameter int TS_DEPTH_P = TS_DEPTH
)
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  avb_link_if.dev          lnk,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_first,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_seq_loss,
  input  wire logic        rx_valid,
  output logic             rx_take,
  input  wire logic        tx_room,
  output logic      [7:0]  tx_byte,
  output logic             tx_first,
  output logic             tx_last,
  output logic             tx_tag,
  output logic             tx_valid
);

  if (TS_DEPTH_P < 1 || TS_DEPTH_P > 7) begin : g_chk
    $error("TS_DEPTH_P must lie between 1 and 7");
  end

  typedef struct packed {
    logic [31:0]                      gcs;
    logic [31:0]                      txpk;
    logic [31:0]                      txctl;
    logic [31:0]                      rxpk;
    logic [31:0]                      rxctl;
    logic [TS_W-1:0]                  txhq2;
    logic [TS_W-1:0]                  tnow;
    logic [TS_DEPTH_P-1:0][TS_W-1:0]  tsq;
    logic [2:0]                       tsn;
    logic                             fs_pend;
    logic                             fs_out;
    logic                             fs_prev;
    logic [3:0]                       div;
    logic                             gclk;
    avb_pins_t                        sa;
    avb_pins_t                        sb;
    logic                             clk_prev;
    logic                             rdy_q;
    logic [7:0]                       d;
    logic                             valid;
    logic                             start;
    logic                             crc;
    logic                             seq;
    logic [7:0]                       txb;
    logic                             txf;
    logic                             txl;
    logic                             txt;
    logic                             txv;
    logic                             ack;
    logic [31:0]                      rdat;
  } avb_dev_st_t;

  avb_dev_st_t st_reg;
  avb_dev_st_t st_next;
  logic        dir;
  logic        clk_oe;
  logic        acc;
  logic        wr;
  logic        push;
  logic        pop;
  logic        edge_seen;
  logic [1:0]  fsel;
  logic [3:0]  half;
  logic [2:0]  cnt;

  function automatic logic [31:0] avb_wmask(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] avb_half(input logic [1:0] fs);
    case (fs)
      FSEL_24: return HALF_24;
      FSEL_12: return HALF_12;
      default: return HALF_6;
    endcase
  endfunction

  assign rx_take = edge_seen & dir & st_reg.rdy_q & rx_valid;

  always_comb
  begin
    st_next   = st_reg;
    dir       = st_reg.gcs[BIT_DIR];
    clk_oe    = dir ? st_reg.rxpk[BIT_CLKOE] : st_reg.txpk[BIT_CLKOE];
    fsel      = dir ? st_reg.rxpk[FSEL_HI:FSEL_LO] : st_reg.txpk[FSEL_HI:FSEL_LO];
    half      = avb_half(fsel);
    acc       = wb_cyc & wb_stb;
    wr        = acc & wb_we & st_reg.ack;
    edge_seen = st_reg.sb.clk & ~st_reg.clk_prev;
    push      = 1'b0;
    cnt       = st_reg.tsn;

    // Register bus: one wait state, read data captured on the same edge that raises ack.
    st_next.ack = acc & ~st_reg.ack;
    if (acc & ~st_reg.ack)
    begin
      case (wb_adr)
        OFS_GCS:   st_next.rdat = st_reg.gcs;
        OFS_TXPK:  st_next.rdat = st_reg.txpk;
        OFS_TXCTL: st_next.rdat = st_reg.txctl;
        OFS_RXPK:  st_next.rdat = st_reg.rxpk;
        OFS_RXCTL: st_next.rdat = st_reg.rxctl;
        OFS_TXHQ2: st_next.rdat = {{(32-TS_W){1'b0}}, st_reg.txhq2};
        OFS_RXHQ2: st_next.rdat = {29'h0, st_reg.tsn};
        default:   st_next.rdat = REG_RST;
      endcase
    end
    if (wr)
    begin
      case (wb_adr)
        OFS_GCS:   st_next.gcs = avb_wmask(st_reg.gcs, wb_dat_w, wb_sel);
        OFS_TXPK:  st_next.txpk = avb_wmask(st_reg.txpk, wb_dat_w, wb_sel);
        OFS_TXCTL: st_next.txctl = avb_wmask(st_reg.txctl, wb_dat_w, wb_sel);
        OFS_RXPK:  st_next.rxpk = avb_wmask(st_reg.rxpk, wb_dat_w, wb_sel);
        OFS_RXCTL: st_next.rxctl = avb_wmask(st_reg.rxctl, wb_dat_w, wb_sel);
        OFS_RXHQ2: push = 1'b1;
        default:   push = 1'b0;
      endcase
    end

    // Clock divider; it idles low so the pin never glitches when enabled.
    if (!clk_oe)
    begin
      st_next.div  = 4'h0;
      st_next.gclk = 1'b0;
    end
    else if (st_reg.div >= half - 4'h1)
    begin
      st_next.div  = 4'h0;
      st_next.gclk = ~st_reg.gclk;
    end
    else
    begin
      st_next.div = st_reg.div + 4'h1;
    end

    st_next.sa       = lnk.pins;
    st_next.sb       = st_reg.sa;
    st_next.clk_prev = st_reg.sb.clk;
    st_next.tnow     = st_reg.tnow + 16'h0001;
    st_next.txv      = 1'b0;

    if (edge_seen)
    begin
      st_next.fs_prev = st_reg.sb.fsync;
      if (!dir)
      begin
        st_next.rdy_q  = tx_room;
        st_next.valid  = 1'b0;
        st_next.start  = 1'b0;
        st_next.fs_out = 1'b0;
        if (st_reg.sb.valid)
        begin
          st_next.txb = st_reg.sb.data;
          st_next.txf = st_reg.sb.start;
          st_next.txl = st_reg.sb.pkt_end;
          st_next.txt = st_reg.sb.tag;
          st_next.txv = 1'b1;
        end
        if (st_reg.sb.fsync & ~st_reg.fs_prev)
        begin
          st_next.txhq2 = st_reg.tnow;
        end
      end
      else
      begin
        st_next.rdy_q  = st_reg.sb.ready;
        st_next.valid  = st_reg.rdy_q & rx_valid;
        st_next.start  = rx_valid & rx_first;
        st_next.fs_out = st_reg.fs_pend;
        st_next.fs_pend = 1'b0;
        if (st_reg.rdy_q & rx_valid)
        begin
          st_next.d = rx_byte;
          if (rx_first)
          begin
            st_next.crc = rx_crc_err;
            st_next.seq = rx_seq_loss;
          end
        end
      end
    end

    // Timestamp queue: head is released as frame sync when the timer meets it.
    pop = dir & (st_reg.tsn != 3'h0) & (st_reg.tsq[0] == st_reg.tnow);
    if (pop)
    begin
      for (int i = 0; i < TS_DEPTH_P - 1; i++)
      begin
        st_next.tsq[i] = st_reg.tsq[i+1];
      end
      st_next.fs_pend = 1'b1;
      cnt = st_reg.tsn - 3'h1;
    end
    if (push && st_reg.tsn < 3'(TS_DEPTH_P))
    begin
      st_next.tsq[cnt] = wb_dat_w[TS_W-1:0];
      cnt = cnt + 3'h1;
    end
    st_next.tsn = cnt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign wb_ack   = st_reg.ack;
  assign wb_dat_r = st_reg.rdat;
  assign tx_byte  = st_reg.txb;
  assign tx_first = st_reg.txf;
  assign tx_last  = st_reg.txl;
  assign tx_tag   = st_reg.txt;
  assign tx_valid = st_reg.txv;

  assign lnk.dev_o = '{clk: st_reg.gclk, data: st_reg.d, valid: st_reg.valid, start: st_reg.start,
                       ready: st_reg.rdy_q & ~dir, fsync: st_reg.fs_out, tag: st_reg.rxctl[BIT_TAG],
                       crc_err: st_reg.crc, seq_loss: st_reg.seq, pkt_end: 1'b0};
  assign lnk.dev_oe = '{clk: clk_oe, data: {8{dir}}, valid: dir, start: dir, ready: ~dir,
                        fsync: dir, tag: dir, crc_err: 1'b1, seq_loss: 1'b1, pkt_end: 1'b0};

endmodule

/* File: hw/avb_codec.sv */
// Purpose: Application-side end of the AV stream port, source or sink of bytes.
// Assumes: Device direction is given on dir; pins pass two flip-flops first.
// Notes:   Sink delivers every byte seen valid, even after it dropped ready.
`timescale 1ns/1ps
module avb_codec
  import avb_pkg::*;
#(
  parameter int CLK_HALF = CODEC_HALF
)
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  avb_link_if.codec       lnk,
  input  wire logic       dir,
  input  wire logic       clk_drive,
  input  wire logic [7:0] src_byte,
  input  wire logic       src_first,
  input  wire logic       src_last,
  input  wire logic       src_tag,
  input  wire logic       src_fs,
  input  wire logic       src_valid,
  output logic            src_take,
  input  wire logic       snk_ready,
  output logic      [7:0] snk_byte,
  output logic            snk_first,
  output logic            snk_crc,
  output logic            snk_seq,
  output logic            snk_tag,
  output logic            snk_fs,
  output logic            snk_valid
);

  if (CLK_HALF < 2 || CLK_HALF > 255) begin : g_chk
    $error("CLK_HALF must lie between 2 and 255");
  end

  typedef struct packed {
    logic [7:0] div;
    logic       gclk;
    avb_pins_t  sa;
    avb_pins_t  sb;
    logic       clk_prev;
    logic       fs_prev;
    logic       fs_pend;
    avb_pins_t  drv;
    logic [7:0] sbyte;
    logic       sfirst;
    logic       scrc;
    logic       sseq;
    logic       stag;
    logic       sfs;
    logic       svalid;
  } avb_cod_st_t;

  avb_cod_st_t st_reg;
  avb_cod_st_t st_next;
  logic        edge_seen;

  assign edge_seen = st_reg.sb.clk & ~st_reg.clk_prev;
  assign src_take  = edge_seen & ~dir & st_reg.sb.ready & src_valid;

  always_comb
  begin
    st_next = st_reg;
    if (!clk_drive)
    begin
      st_next.div  = 8'h00;
      st_next.gclk = 1'b0;
    end
    else if (st_reg.div >= 8'(CLK_HALF - 1))
    begin
      st_next.div  = 8'h00;
      st_next.gclk = ~st_reg.gclk;
    end
    else
    begin
      st_next.div = st_reg.div + 8'h01;
    end

    st_next.sa       = lnk.pins;
    st_next.sb       = st_reg.sa;
    st_next.clk_prev = st_reg.sb.clk;
    st_next.svalid   = 1'b0;
    st_next.sfs      = 1'b0;
    st_next.fs_pend  = st_reg.fs_pend | src_fs;

    if (edge_seen)
    begin
      st_next.fs_prev = st_reg.sb.fsync;
      st_next.drv     = '0;
      if (!dir)
      begin
        st_next.drv.fsync = st_reg.fs_pend;
        st_next.fs_pend   = src_fs;
        if (st_reg.sb.ready & src_valid)
        begin
          st_next.drv.data    = src_byte;
          st_next.drv.valid   = 1'b1;
          st_next.drv.start   = src_first;
          st_next.drv.pkt_end = src_last;
          st_next.drv.tag     = src_tag;
        end
      end
      else
      begin
        st_next.drv.ready = snk_ready;
        st_next.stag      = st_reg.sb.tag;
        st_next.sfs       = st_reg.sb.fsync & ~st_reg.fs_prev;
        if (st_reg.sb.valid)
        begin
          st_next.sbyte  = st_reg.sb.data;
          st_next.sfirst = st_reg.sb.start;
          st_next.scrc   = st_reg.sb.crc_err;
          st_next.sseq   = st_reg.sb.seq_loss;
          st_next.svalid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign snk_byte  = st_reg.sbyte;
  assign snk_first = st_reg.sfirst;
  assign snk_crc   = st_reg.scrc;
  assign snk_seq   = st_reg.sseq;
  assign snk_tag   = st_reg.stag;
  assign snk_fs    = st_reg.sfs;
  assign snk_valid = st_reg.svalid;

  assign lnk.cod_o = '{clk: st_reg.gclk, data: st_reg.drv.data, valid: st_reg.drv.valid,
                       start: st_reg.drv.start, ready: st_reg.drv.ready, fsync: st_reg.drv.fsync,
                       tag: st_reg.drv.tag, crc_err: 1'b0, seq_loss: 1'b0, pkt_end: st_reg.drv.pkt_end};
  assign lnk.cod_oe = '{clk: clk_drive, data: {8{~dir}}, valid: ~dir, start: ~dir, ready: dir,
                        fsync: ~dir, tag: ~dir, crc_err: 1'b0, seq_loss: 1'b0, pkt_end: ~dir};

endmodule

/* File: bench/avb_link_properties.sv */
// Purpose: Pin-level checks between the device end and the codec end.
// Assumes: Pins are watched on sys_clk, not on the app clock.
// Notes:   Valid must fall within 48 cycles of ready low, three slow app periods.
`timescale 1ns/1ps
module avb_link_properties
  import avb_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rstn,
  input wire avb_pins_t dev_o,
  input wire avb_pins_t dev_oe,
  input wire avb_pins_t cod_oe,
  input wire avb_pins_t pins
);
  logic [7:0] hc_reg;
  logic       seen_reg;
  logic [7:0] lo_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // The first half period after enable may be partial, so it is only counted once seen.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !dev_oe.clk || $changed(dev_o.clk))
      hc_reg <= 8'h01;
    else if (hc_reg != 8'hff)
      hc_reg <= hc_reg + 8'h01;
    if (!rstn || !dev_oe.clk)
      seen_reg <= 1'b0;
    else if ($changed(dev_o.clk))
      seen_reg <= 1'b1;
    if (!rstn || pins.ready)
      lo_reg <= 8'h00;
    else if (lo_reg != 8'hff)
      lo_reg <= lo_reg + 8'h01;
  end

  sequence clk_flip;
    dev_oe.clk && $past(dev_oe.clk) && $changed(dev_o.clk) && seen_reg;
  endsequence

  sequence first_out;
    dev_o.start && dev_o.valid;
  endsequence

  a_clk_single: assert property (!(dev_oe.clk && cod_oe.clk))
    else $error("app clock driven by both ends");
  a_clk_period: assert property (clk_flip |-> hc_reg == 8'(HALF_24) || hc_reg == 8'(HALF_12)
    || hc_reg == 8'(HALF_6))
    else $error("app clock half period off");
  a_dir_default: assert property ($rose(rstn) |-> dev_oe.ready && !dev_oe.valid)
    else $error("device not transmitting after reset");
  a_dev_dir: assert property (dev_oe.tag == dev_oe.valid && dev_oe.fsync == dev_oe.valid)
    else $error("device tag or frame sync direction wrong");
  a_ready_dir: assert property (dev_oe.ready != cod_oe.ready && dev_oe.valid != cod_oe.valid)
    else $error("ready direction wrong");
  a_err_out: assert property (dev_oe.valid |-> dev_oe.crc_err && dev_oe.seq_loss)
    else $error("error flags not driven");
  a_flag_hold: assert property ($changed(dev_o.crc_err) || $changed(dev_o.seq_loss) |-> first_out)
    else $error("error flag moved outside packet start");
  a_start_hold: assert property ($fell(dev_o.start) |-> $past(dev_o.valid))
    else $error("start dropped before first byte");
  a_withhold: assert property (lo_reg > 8'h30 && dev_oe.valid |-> !dev_o.valid)
    else $error("byte presented while ready low");
endmodule

/* File: bench/testbench.sv */
// Purpose: Self-checking bench for both ends of the AV stream port.
// Assumes: Bench inputs change by non-blocking update at sys_clk rise.
// Notes:   Far-future timestamps stay queued; the run ends before they fall due.
`timescale 1ns/1ps
module testbench;
  import avb_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0]  wb_adr = 8'h00, tx_byte, snk_byte;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, seed = 32'h0000_f29b, fr;
  logic [11:0] rx_head = 12'h000, rmem[128] = '{default: 12'h000};
  logic [10:0] src_head = 11'h000, smem[128] = '{default: 11'h000};
  logic        rx_valid = 1'b0, rx_take, tx_room = 1'b0, tx_first, tx_last, tx_tag, tx_valid;
  logic        dir = 1'b0, clk_drive = 1'b0, src_fs = 1'b0, src_valid = 1'b0, src_take, snk_ready = 1'b0;
  logic        snk_first, snk_crc, snk_seq, snk_tag, snk_fs, snk_valid, tag_exp = 1'b0;
  int          fail_count = 0, n_compared = 0, ri = 0, rn = 0, rw = 0, si = 0, sn = 0, sw = 0;
  int          tcnt = 0, scnt = 0, cyc = 0, fs_seen = 0;
  logic [7:0]  reg_ofs[5] = '{OFS_GCS, OFS_TXPK, OFS_TXCTL, OFS_RXPK, OFS_RXCTL};

  avb_link_if u_avb_link_if ();
  avb_dev #(.TS_DEPTH_P(TS_DEPTH)) u_avb_dev (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .lnk(u_avb_link_if), .rx_byte(rx_head[7:0]), .rx_first(rx_head[8]),
    .rx_crc_err(rx_head[9]), .rx_seq_loss(rx_head[10]), .rx_valid(rx_valid), .rx_take(rx_take),
    .tx_room(tx_room), .tx_byte(tx_byte), .tx_first(tx_first), .tx_last(tx_last), .tx_tag(tx_tag),
    .tx_valid(tx_valid));
  avb_codec #(.CLK_HALF(CODEC_HALF)) u_avb_codec (.sys_clk(sys_clk), .rstn(rstn), .lnk(u_avb_link_if),
    .dir(dir), .clk_drive(clk_drive), .src_byte(src_head[7:0]), .src_first(src_head[8]),
    .src_last(src_head[9]), .src_tag(src_head[10]), .src_fs(src_fs), .src_valid(src_valid),
    .src_take(src_take), .snk_ready(snk_ready), .snk_byte(snk_byte), .snk_first(snk_first), .snk_crc(snk_crc),
    .snk_seq(snk_seq), .snk_tag(snk_tag), .snk_fs(snk_fs), .snk_valid(snk_valid));
  avb_link_properties u_avb_link_properties (.sys_clk(sys_clk), .rstn(rstn), .dev_o(u_avb_link_if.dev_o),
    .dev_oe(u_avb_link_if.dev_oe), .cod_oe(u_avb_link_if.cod_oe), .pins(u_avb_link_if.pins));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_strm(input logic [11:0] got, input logic [11:0] exp);
    cmp_reg({20'h0, got}, {20'h0, exp});
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= s;
    do
      @(posedge sys_clk);
    while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    cmp_reg(q, e);
  endtask

  // Packets of 1 and 4 bytes come first: a lone first byte, then one with no end mark.
  task automatic load(input logic rxs, input int npk);
    int          len;
    logic [31:0] pk, v;
    for (int p = 0; p < npk; p++)
    begin
      pk = rnd();
      len = (p < 2) ? 1 + 3 * p : 1 + int'(pk[3:0] % 4'h9);
      for (int b = 0; b < len; b++)
      begin
        v = rnd();
        if (rxs)
          rmem[rw[6:0]] = {tag_exp, pk[5:4], b == 0, v[7:0]};
        else
          smem[sw[6:0]] = {pk[6], (b == len - 1) && (len % 4 != 0), b == 0, v[7:0]};
        rw = rw + int'(rxs);
        sw = sw + int'(!rxs);
      end
    end
    rn <= rw;
    sn <= sw;
    for (int n = 0; n < 30000 && (rxs ? scnt < rw : tcnt < sw); n++)
      @(posedge sys_clk);
    cmp_reg(32'(rxs ? scnt : tcnt), 32'(rxs ? rw : sw));
  endtask

  // Ready and room drop for long spans so both flow-control paths really stall.
  always @(posedge sys_clk)
  begin
    ri = ri + int'(rx_take);
    si = si + int'(src_take);
    fr = rnd();
    rx_head <= rmem[ri[6:0]];
    rx_valid <= ri < rn;
    src_head <= smem[si[6:0]];
    src_valid <= si < sn;
    tx_room <= cyc[9:7] != 3'h1 && fr[1:0] != 2'h0;
    snk_ready <= cyc[8:6] != 3'h0 && fr[3:2] != 2'h0;
    cyc <= rstn ? cyc + 1 : 0;
    if (tx_valid === 1'b1)
    begin
      cmp_strm({1'b0, tx_tag, tx_last, tx_first, tx_byte}, {1'b0, smem[tcnt[6:0]]});
      tcnt = tcnt + 1;
    end
    if (snk_valid === 1'b1)
    begin
      cmp_strm({snk_tag, snk_seq, snk_crc, snk_first, snk_byte}, rmem[scnt[6:0]]);
      scnt = scnt + 1;
    end
    if (snk_fs === 1'b1)
      fs_seen = fs_seen + 1;
  end

  initial
  begin
    logic [31:0] q;
    int          t0, f0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (reg_ofs[i])
      chk_rd(reg_ofs[i], REG_RST);
    wr(8'h7c, 32'hffff_ffff, 4'hf);
    chk_rd(8'h7c, 32'h0000_0000);
    wr(OFS_TXCTL, 32'hffff_ffff, 4'h2);
    chk_rd(OFS_TXCTL, 32'h0000_ff00);
    wr(OFS_TXCTL, 32'h0000_0000, 4'hf);
    clk_drive <= 1'b1;
    load(1'b0, 10);
    src_fs <= 1'b1;
    @(posedge sys_clk);
    src_fs <= 1'b0;
    t0 = cyc - 8;
    repeat (64) @(posedge sys_clk);
    wb(1'b0, OFS_TXHQ2, 32'h0, 4'hf, q);
    cmp_reg({31'h0, q[15:0] - t0[15:0] < 16'h0050}, 32'h0000_0001);
    clk_drive <= 1'b0;
    repeat (20) @(posedge sys_clk);
    wr(OFS_GCS, 32'h0000_0001, 4'hf);
    dir <= 1'b1;
    for (int f = 0; f < 3; f++)
    begin
      tag_exp = f[0];
      wr(OFS_RXCTL, {31'h0, tag_exp}, 4'hf);
      wr(OFS_RXPK, 32'(2 * f + 1), 4'hf);
      load(1'b1, 8);
      wr(OFS_RXPK, 32'h0000_0000, 4'hf);
      repeat (20) @(posedge sys_clk);
    end
    wr(OFS_RXPK, 32'h0000_0001, 4'hf);
    f0 = fs_seen;
    wr(OFS_RXHQ2, 32'(cyc[15:0] + 16'h00c8), 4'hf);
    chk_rd(OFS_RXHQ2, 32'h0000_0001);
    for (int n = 0; n < 600 && fs_seen == f0; n++)
      @(posedge sys_clk);
    cmp_reg(32'(fs_seen - f0), 32'h0000_0001);
    chk_rd(OFS_RXHQ2, 32'h0000_0000);
    repeat (TS_DEPTH + 1)
      wr(OFS_RXHQ2, 32'(cyc[15:0] + 16'h8000), 4'hf);
    chk_rd(OFS_RXHQ2, 32'(TS_DEPTH));
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fail_count = fail_count + 1;
    summarize();
  end
endmodule
